// *** logic/scsp_pkg.sv ***
package scsp_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CLOCK_DIVISOR_REGISTER_OFF = 8'h00;
    localparam logic [7:0] FBD_OFF = 8'h04;
    localparam logic [7:0] TUNE_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0c;
    localparam logic [15:0] CLOCK_DIVISOR_REGISTER_RST = 16'h3040;
    localparam logic [8:0] FBD_RST = 9'h030;
    localparam logic [5:0] TUNE_RST = 6'h00;
    localparam logic [15:0] CLOCK_DIVISOR_REGISTER_MASK = 16'hffdf;
    // ----------------------------------------
    // status field positions
    // ----------------------------------------
    localparam int ST_SRC_LSB = 0;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_LOCK_BIT = 8;
    localparam int ST_PLL_BIT = 9;
    // ----------------------------------------
    // fixed factors, lock count and bus response codes
    // ----------------------------------------
    localparam logic [8:0] FAST_DIV16 = 9'h010;
    localparam logic [8:0] FCY_DIV = 9'h002;
    localparam logic [8:0] FACTOR_OFFSET = 9'h002;
    localparam logic [1:0] LOCK_REF_TICKS = 2'h2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SRC_FAST = 3'h0,
        SRC_FAST_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_SLOW = 3'h5,
        SRC_FAST_DIV16 = 3'h6,
        SRC_FAST_DIVN = 3'h7
    } scsp_src_t;

    typedef enum logic [1:0] {
        MODE_EXT_CLOCK = 2'h0,
        MODE_STD_XTAL = 2'h1,
        MODE_HS_XTAL = 2'h2,
        MODE_RESERVED = 2'h3
    } scsp_mode_t;

    typedef struct packed {
        logic recover_on_irq;
        logic [2:0] doze_ratio;
        logic doze_enable;
        logic [2:0] fast_rc_postscale_select;
        logic [1:0] pll_postscale_select;
        logic unused5;
        logic [4:0] pll_prescale_select;
    } scsp_clock_divisor_register_t;
endpackage

// *** logic/scsp_sync_edge.sv ***
module scsp_sync_edge (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic rise_o
);
    logic ff1_r, ff2_r, ff3_r, level_r, rise_r;
    logic level_nxt, rise_nxt;

    // a change counts only once the second and third stages agree
    always_comb begin
        level_nxt = (ff2_r == ff3_r) ? ff3_r : level_r;
        rise_nxt = level_nxt & ~level_r;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ff1_r <= 1'b0;
            ff2_r <= 1'b0;
            ff3_r <= 1'b0;
            level_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            ff1_r <= async_i;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            level_r <= level_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign rise_o = rise_r;
endmodule

// *** logic/scsp_tick_div.sv ***
module scsp_tick_div (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic [8:0] divisor_i,
    output logic tick_o
);
    logic [8:0] cnt_r, cnt_nxt, div_r, div_nxt;
    logic tick_r, tick_nxt;

    // new divisor is taken only at the terminal count, so no short period appears
    always_comb begin
        cnt_nxt = cnt_r;
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (tick_i) begin
            if (cnt_r + 9'h001 >= div_r) begin
                cnt_nxt = 9'h000;
                tick_nxt = 1'b1;
                div_nxt = (divisor_i == 9'h000) ? 9'h001 : divisor_i;
            end else begin
                cnt_nxt = cnt_r + 9'h001;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= 9'h000;
            div_r <= 9'h001;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule

// *** logic/scsp_top.sv ***
module scsp_top (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic fast_osc_i,
    input wire logic slow_osc_i,
    input wire logic secondary_osc_i,
    input wire logic primary_osc_i,
    input wire logic [2:0] initial_source_select_i,
    input wire logic [1:0] primary_mode_select_i,
    output logic sys_osc_tick_o,
    output logic instr_clock_o,
    output logic peripheral_clock_o,
    output logic watchdog_ref_tick_o,
    output logic fail_safe_ref_tick_o,
    output logic [5:0] fast_osc_tune_o,
    output logic [1:0] primary_drive_mode_o,
    output logic pll_lock_o
);
    // ----------------------------------------
    // oscillator inputs
    // ----------------------------------------
    logic fast_tick, slow_tick, sec_tick, prim_tick;

    scsp_sync_edge u_sync_fast (.clock_i(clock_i), .reset_i(reset_i), .async_i(fast_osc_i), .rise_o(fast_tick));
    scsp_sync_edge u_sync_slow (.clock_i(clock_i), .reset_i(reset_i), .async_i(slow_osc_i), .rise_o(slow_tick));
    scsp_sync_edge u_sync_sec (.clock_i(clock_i), .reset_i(reset_i), .async_i(secondary_osc_i),
        .rise_o(sec_tick));
    scsp_sync_edge u_sync_prim (.clock_i(clock_i), .reset_i(reset_i), .async_i(primary_osc_i),
        .rise_o(prim_tick));

    // ----------------------------------------
    // power-on configuration capture
    // ----------------------------------------
    // straps are read by a clocked process after release, never by the reset itself
    scsp_pkg::scsp_src_t src_r, src_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic cfg_done_r, cfg_done_nxt;

    always_comb begin
        src_nxt = src_r;
        mode_nxt = mode_r;
        cfg_done_nxt = 1'b1;
        if (!cfg_done_r) begin
            src_nxt = scsp_pkg::scsp_src_t'(initial_source_select_i);
            mode_nxt = primary_mode_select_i;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            src_r <= scsp_pkg::SRC_FAST_DIVN;
            mode_r <= scsp_pkg::MODE_EXT_CLOCK;
            cfg_done_r <= 1'b0;
        end else begin
            src_r <= src_nxt;
            mode_r <= mode_nxt;
            cfg_done_r <= cfg_done_nxt;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    scsp_pkg::scsp_clock_divisor_register_t clock_divisor_register_r, clock_divisor_register_nxt;
    logic [8:0] fbd_r, fbd_nxt;
    logic [5:0] tune_r, tune_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic pll_lock, pll_used;
    logic [31:0] status_word, wmask;
    logic [15:0] clock_divisor_register_word;

    assign awready_o = !aw_held_r && !bvalid_r;
    assign wready_o = !w_held_r && !bvalid_r;
    assign arready_o = !rvalid_r;
    assign clock_divisor_register_word = clock_divisor_register_r;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[scsp_pkg::ST_SRC_LSB +: 3] = src_r;
        status_word[scsp_pkg::ST_MODE_LSB +: 2] = mode_r;
        status_word[scsp_pkg::ST_LOCK_BIT] = pll_lock;
        status_word[scsp_pkg::ST_PLL_BIT] = pll_used;
    end

    always_comb begin
        wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    end

    always_comb begin
        aw_addr_nxt = aw_addr_r;
        aw_held_nxt = aw_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        w_held_nxt = w_held_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        clock_divisor_register_nxt = clock_divisor_register_r;
        fbd_nxt = fbd_r;
        tune_nxt = tune_r;
        if (awvalid_i && awready_o) begin
            aw_addr_nxt = awaddr_i;
            aw_held_nxt = 1'b1;
        end
        if (wvalid_i && wready_o) begin
            w_data_nxt = wdata_i;
            w_strb_nxt = wstrb_i;
            w_held_nxt = 1'b1;
        end
        if (bvalid_r && bready_i) begin
            bvalid_nxt = 1'b0;
        end
        // write commits one cycle after both address and data are held
        if (aw_held_r && w_held_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = scsp_pkg::AXI_OKAY;
            case ({aw_addr_r[7:2], 2'b00})
                scsp_pkg::CLOCK_DIVISOR_REGISTER_OFF: begin
                    clock_divisor_register_nxt = (clock_divisor_register_word & ~(wmask[15:0] & scsp_pkg::CLOCK_DIVISOR_REGISTER_MASK))
                        | (w_data_r[15:0] & wmask[15:0] & scsp_pkg::CLOCK_DIVISOR_REGISTER_MASK);
                end
                scsp_pkg::FBD_OFF: begin
                    fbd_nxt = (fbd_r & ~wmask[8:0]) | (w_data_r[8:0] & wmask[8:0]);
                end
                scsp_pkg::TUNE_OFF: begin
                    tune_nxt = (tune_r & ~wmask[5:0]) | (w_data_r[5:0] & wmask[5:0]);
                end
                scsp_pkg::STATUS_OFF: begin
                    bresp_nxt = scsp_pkg::AXI_OKAY;
                end
                default: begin
                    bresp_nxt = scsp_pkg::AXI_SLVERR;
                end
            endcase
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && rready_i) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid_i && arready_o) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = scsp_pkg::AXI_OKAY;
            case ({araddr_i[7:2], 2'b00})
                scsp_pkg::CLOCK_DIVISOR_REGISTER_OFF: rdata_nxt = {16'h0000, clock_divisor_register_word};
                scsp_pkg::FBD_OFF: rdata_nxt = {23'h0, fbd_r};
                scsp_pkg::TUNE_OFF: rdata_nxt = {26'h0, tune_r};
                scsp_pkg::STATUS_OFF: rdata_nxt = status_word;
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = scsp_pkg::AXI_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            aw_addr_r <= 8'h00;
            aw_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
            clock_divisor_register_r <= scsp_pkg::CLOCK_DIVISOR_REGISTER_RST;
            fbd_r <= scsp_pkg::FBD_RST;
            tune_r <= scsp_pkg::TUNE_RST;
        end else begin
            aw_addr_r <= aw_addr_nxt;
            aw_held_r <= aw_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            w_held_r <= w_held_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            clock_divisor_register_r <= clock_divisor_register_nxt;
            fbd_r <= fbd_nxt;
            tune_r <= tune_nxt;
        end
    end

    assign bvalid_o = bvalid_r;
    assign bresp_o = bresp_r;
    assign rvalid_o = rvalid_r;
    assign rdata_o = rdata_r;
    assign rresp_o = rresp_r;

    // ----------------------------------------
    // factor decode
    // ----------------------------------------
    logic [8:0] fast_div, pre_div, post_div;
    logic [9:0] fb_mult;

    always_comb begin
        case (clock_divisor_register_r.fast_rc_postscale_select)
            3'h0: fast_div = 9'h001;
            3'h1: fast_div = 9'h002;
            3'h2: fast_div = 9'h004;
            3'h3: fast_div = 9'h008;
            3'h4: fast_div = 9'h010;
            3'h5: fast_div = 9'h020;
            3'h6: fast_div = 9'h040;
            default: fast_div = 9'h100;
        endcase
        case (clock_divisor_register_r.pll_postscale_select)
            2'h0: post_div = 9'h002;
            2'h3: post_div = 9'h008;
            default: post_div = 9'h004;
        endcase
        pre_div = {4'h0, clock_divisor_register_r.pll_prescale_select} + scsp_pkg::FACTOR_OFFSET;
        fb_mult = {1'b0, fbd_r} + {1'b0, scsp_pkg::FACTOR_OFFSET};
        pll_used = (src_r == scsp_pkg::SRC_FAST_PLL) || (src_r == scsp_pkg::SRC_PRIMARY_PLL);
    end

    // ----------------------------------------
    // source paths
    // ----------------------------------------
    logic fast_divn_tick, fast_div16_tick, pll_in_tick, pre_tick, vco_tick, pll_out_tick;

    scsp_tick_div u_fast_divn (.clock_i(clock_i), .reset_i(reset_i), .tick_i(fast_tick),
        .divisor_i(fast_div), .tick_o(fast_divn_tick));
    scsp_tick_div u_fast_div16 (.clock_i(clock_i), .reset_i(reset_i), .tick_i(fast_tick),
        .divisor_i(scsp_pkg::FAST_DIV16), .tick_o(fast_div16_tick));

    // only primary and fast RC may feed the PLL
    assign pll_in_tick = (src_r == scsp_pkg::SRC_PRIMARY_PLL) ? prim_tick
        : (src_r == scsp_pkg::SRC_FAST_PLL) ? fast_tick : 1'b0;

    scsp_tick_div u_pll_pre (.clock_i(clock_i), .reset_i(reset_i), .tick_i(pll_in_tick),
        .divisor_i(pre_div), .tick_o(pre_tick));

    // ----------------------------------------
    // vco model: M ticks spread over each measured reference period
    // ----------------------------------------
    // output rate is capped at one tick per system cycle; a limitation of the model
    logic [15:0] per_cnt_r, per_cnt_nxt, period_r, period_nxt;
    logic [19:0] acc_r, acc_nxt;
    logic [1:0] ref_seen_r, ref_seen_nxt;
    logic vco_r, vco_nxt;

    always_comb begin
        per_cnt_nxt = (per_cnt_r == 16'hffff) ? per_cnt_r : per_cnt_r + 16'h0001;
        period_nxt = period_r;
        ref_seen_nxt = ref_seen_r;
        acc_nxt = acc_r;
        vco_nxt = 1'b0;
        if (!pll_used) begin
            ref_seen_nxt = 2'h0;
            acc_nxt = 20'h00000;
        end else begin
            if (pre_tick) begin
                period_nxt = per_cnt_r;
                per_cnt_nxt = 16'h0001;
                if (ref_seen_r != scsp_pkg::LOCK_REF_TICKS) begin
                    ref_seen_nxt = ref_seen_r + 2'h1;
                end
            end
            if (ref_seen_r == scsp_pkg::LOCK_REF_TICKS) begin
                acc_nxt = acc_r + {10'h000, fb_mult};
                if (acc_nxt >= {4'h0, period_r}) begin
                    acc_nxt = acc_nxt - {4'h0, period_r};
                    vco_nxt = 1'b1;
                end
                if (acc_nxt >= {4'h0, period_r}) begin
                    acc_nxt = {4'h0, period_r};
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            per_cnt_r <= 16'h0000;
            period_r <= 16'hffff;
            acc_r <= 20'h00000;
            ref_seen_r <= 2'h0;
            vco_r <= 1'b0;
        end else begin
            per_cnt_r <= per_cnt_nxt;
            period_r <= period_nxt;
            acc_r <= acc_nxt;
            ref_seen_r <= ref_seen_nxt;
            vco_r <= vco_nxt;
        end
    end

    assign vco_tick = vco_r;
    assign pll_lock = (ref_seen_r == scsp_pkg::LOCK_REF_TICKS);

    scsp_tick_div u_pll_post (.clock_i(clock_i), .reset_i(reset_i), .tick_i(vco_tick),
        .divisor_i(post_div), .tick_o(pll_out_tick));

    // ----------------------------------------
    // system clock select and halving
    // ----------------------------------------
    logic osc_sel;
    logic osc_r, osc_nxt, fcy_r, fcy_nxt;

    always_comb begin
        case (src_r)
            scsp_pkg::SRC_FAST_DIVN: osc_sel = fast_divn_tick;
            scsp_pkg::SRC_FAST_DIV16: osc_sel = fast_div16_tick;
            scsp_pkg::SRC_SLOW: osc_sel = slow_tick;
            scsp_pkg::SRC_SECONDARY: osc_sel = sec_tick;
            scsp_pkg::SRC_PRIMARY_PLL: osc_sel = pll_out_tick;
            scsp_pkg::SRC_PRIMARY: osc_sel = prim_tick;
            scsp_pkg::SRC_FAST_PLL: osc_sel = pll_out_tick;
            default: osc_sel = fast_tick;
        endcase
        osc_nxt = osc_sel & cfg_done_r;
        // one toggle per system tick: a full level period spans two ticks
        fcy_nxt = osc_r ? ~fcy_r : fcy_r;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            osc_r <= 1'b0;
            fcy_r <= 1'b0;
        end else begin
            osc_r <= osc_nxt;
            fcy_r <= fcy_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign sys_osc_tick_o = osc_r;
    assign instr_clock_o = fcy_r;
    assign peripheral_clock_o = fcy_r;
    assign watchdog_ref_tick_o = slow_tick;
    assign fail_safe_ref_tick_o = slow_tick;
    assign fast_osc_tune_o = tune_r;
    // mode field only matters for primary selections
    assign primary_drive_mode_o = ((src_r == scsp_pkg::SRC_PRIMARY) || (src_r == scsp_pkg::SRC_PRIMARY_PLL))
        ? mode_r : scsp_pkg::MODE_EXT_CLOCK;
    assign pll_lock_o = pll_lock;
endmodule

// *** verification/scsp_osc_model.sv ***
module scsp_osc_model #(
    parameter int HALF_NS = 100,
    parameter int START_NS = 13
) (
    output logic osc_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // free running: crystals and rc sources never pause
    initial begin
        osc_o = 1'b0;
        #(START_NS);
        forever #(HALF_NS) osc_o = ~osc_o;
    end
endmodule

// *** verification/scsp_top_asserts.sv ***
module scsp_top_asserts (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic bvalid_o,
    input wire logic bready_i,
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic rvalid_o,
    input wire logic rready_i,
    input wire logic slow_osc_i,
    input wire logic [2:0] initial_source_select_i,
    input wire logic [1:0] primary_mode_select_i,
    input wire logic sys_osc_tick_o,
    input wire logic instr_clock_o,
    input wire logic peripheral_clock_o,
    input wire logic watchdog_ref_tick_o,
    input wire logic fail_safe_ref_tick_o,
    input wire logic [1:0] primary_drive_mode_o,
    input wire logic pll_lock_o
);
    logic [2:0] age_r, age_nxt, src_r, src_nxt;
    logic [1:0] mode_r, mode_nxt, cnt_r, cnt_nxt;
    logic fcy_r, fcy_nxt;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // straps latched once, ticks since last toggle
    // ----------------------------------------
    always_comb begin
        age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
        src_nxt = (age_r == 3'h0) ? initial_source_select_i : src_r;
        mode_nxt = (age_r == 3'h0) ? primary_mode_select_i : mode_r;
        fcy_nxt = instr_clock_o;
        if (instr_clock_o != fcy_r)
            cnt_nxt = 2'h0;
        else if (sys_osc_tick_o && cnt_r != 2'h3)
            cnt_nxt = cnt_r + 2'h1;
        else
            cnt_nxt = cnt_r;
    end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            {age_r, src_r, mode_r, cnt_r, fcy_r} <= '0;
        end else begin
            {age_r, src_r, mode_r, cnt_r, fcy_r} <= {age_nxt, src_nxt, mode_nxt, cnt_nxt, fcy_nxt};
        end
    end
    sequence s_wr_taken;
        awvalid_i && awready_o && wvalid_i && wready_o;
    endsequence
    sequence s_slow_rise;
        $rose(slow_osc_i);
    endsequence
    AST_FCY_PAIR: assert property (instr_clock_o == peripheral_clock_o)
        else $error("instruction and peripheral clocks differ");
    AST_FCY_HALF: assert property (cnt_r != 2'h2)
        else $error("instruction clock missed its toggle after a tick");
    AST_REF_PAIR: assert property (watchdog_ref_tick_o == fail_safe_ref_tick_o)
        else $error("watchdog and monitor reference ticks differ");
    AST_REF_LAT: assert property (s_slow_rise |-> ##[1:6] watchdog_ref_tick_o)
        else $error("slow oscillator edge gave no reference tick");
    AST_DRIVE_MODE: assert property (age_r > 3'h2 |-> primary_drive_mode_o == (src_r[2:1] == 2'h1 ? mode_r : 2'h0))
        else $error("primary drive mode wrong for latched straps");
    AST_PLL_ONLY: assert property (age_r > 3'h2 && !(!src_r[2] && src_r[0]) |-> !pll_lock_o)
        else $error("lock reported on a source without the loop");
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] bvalid_o)
        else $error("write response late");
    AST_RD_ANSWER: assert property (arvalid_i && arready_o |=> rvalid_o)
        else $error("read response late");
    AST_B_HOLD: assert property (bvalid_o && !bready_i |=> bvalid_o)
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid_o && !rready_i |=> rvalid_o)
        else $error("read response dropped");
endmodule
bind scsp_top scsp_top_asserts chk (.*);

// *** verification/system_clock_select_pll_tb.sv ***
module system_clock_select_pll_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, reset_i = 1'b1, awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
    logic arvalid_i = 1'b0, rready_i = 1'b0;
    logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, w;
    logic [3:0] wstrb_i = 4'hf;
    logic [2:0] initial_source_select_i = 3'h7;
    logic [1:0] primary_mode_select_i = 2'h0, bresp_o, rresp_o, primary_drive_mode_o;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, sys_osc_tick_o, instr_clock_o;
    logic peripheral_clock_o, watchdog_ref_tick_o, fail_safe_ref_tick_o, pll_lock_o;
    logic fast_osc_i, slow_osc_i, secondary_osc_i, primary_osc_i;
    logic [5:0] fast_osc_tune_o, v;
    logic [33:0] e, exp_q[$];
    localparam logic [33:0] OK_W = {scsp_pkg::AXI_OKAY, 32'h0};
    localparam logic [33:0] ERR_W = {scsp_pkg::AXI_SLVERR, 32'h0};
    int num_errors = 0, n_tests = 0, cycles = 0, seed = 88102;
    int per_tab[4] = '{64, 40, 24, 4};
    logic [2:0] src_tab[4] = '{3'h6, 3'h5, 3'h4, 3'h0};
    scsp_top dut (.*);
    // periods in bench clocks: fast 4, primary 6, secondary 24, slow 40
    scsp_osc_model fast_m (.osc_o(fast_osc_i));
    scsp_osc_model #(.HALF_NS(150)) prim_m (.osc_o(primary_osc_i));
    scsp_osc_model #(.HALF_NS(600)) sec_m (.osc_o(secondary_osc_i));
    scsp_osc_model #(.HALF_NS(1000)) slow_m (.osc_o(slow_osc_i));
    initial forever #25 clock_i = ~clock_i;
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // bus master: handshakes seen at negedge, released after the rising edge
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
        logic pa, pw, ta, tw;
        exp_q.push_back(x);
        pa = 1'b1;
        pw = wr;
        awaddr_i <= a;
        araddr_i <= a;
        wdata_i <= d;
        awvalid_i <= wr;
        wvalid_i <= wr;
        bready_i <= wr;
        arvalid_i <= !wr;
        rready_i <= !wr;
        while (pa || pw) begin
            @(negedge clock_i);
            ta = pa && (wr ? awready_o : arready_o);
            tw = pw && wready_o;
            @(posedge clock_i);
            if (ta) begin
                awvalid_i <= 1'b0;
                arvalid_i <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wvalid_i <= 1'b0;
                pw = 1'b0;
            end
        end
        do begin
            @(negedge clock_i);
            ta = wr ? bvalid_o : rvalid_o;
            @(posedge clock_i);
        end while (!ta);
        bready_i <= 1'b0;
        rready_i <= 1'b0;
        @(posedge clock_i);
    endtask
    always @(negedge clock_i) begin
        if ((bvalid_o && bready_i) || (rvalid_o && rready_i)) begin
            e = exp_q.pop_front();
            check("resp", 32'(bvalid_o ? bresp_o : rresp_o), 32'(e[33:32]));
            if (rvalid_o) check("rdata", rdata_o, e[31:0]);
        end
    end
    task automatic restart(input logic [2:0] s, input logic [1:0] m);
        reset_i <= 1'b1;
        initial_source_select_i <= s;
        primary_mode_select_i <= m;
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        initial_source_select_i <= 3'($random(seed));
    endtask
    // about ten system ticks and as many clock toggles in ten periods
    task automatic measure(input int p);
        int n, t;
        logic last;
        n = 0;
        t = 0;
        repeat (2 * p + 50) @(posedge clock_i);
        @(negedge clock_i);
        last = instr_clock_o;
        repeat (10 * p) begin
            @(negedge clock_i);
            n += int'(sys_osc_tick_o);
            t += int'(instr_clock_o !== last);
            last = instr_clock_o;
        end
        check("tick_count", 32'(n >= 9 && n <= 11), 32'h1);
        check("fcy_toggles", 32'(t >= 9 && t <= 11), 32'h1);
        @(posedge clock_i);
    endtask
    // frequencies scaled to the bench clock; ranges kept in the same ratios
    task automatic pll(input logic [4:0] pre, input logic [8:0] fb, input logic [1:0] post, input int p);
        bus(1'b1, scsp_pkg::FBD_OFF, {23'h0, fb}, OK_W);
        bus(1'b1, scsp_pkg::CLOCK_DIVISOR_REGISTER_OFF, {24'h0, post, 1'b0, pre}, OK_W);
        measure(p);
        check("pll_lock_o", 32'(pll_lock_o), 32'h1);
    endtask
    initial begin
        restart(3'h7, 2'h0);
        measure(4);
        bus(1'b0, scsp_pkg::CLOCK_DIVISOR_REGISTER_OFF, 32'h0, {scsp_pkg::AXI_OKAY, 16'h0, scsp_pkg::CLOCK_DIVISOR_REGISTER_RST});
        bus(1'b0, scsp_pkg::FBD_OFF, 32'h0, {scsp_pkg::AXI_OKAY, 23'h0, scsp_pkg::FBD_RST});
        v = 6'($random(seed));
        bus(1'b1, scsp_pkg::TUNE_OFF, {26'h0, v}, OK_W);
        wstrb_i <= 4'he;
        bus(1'b1, scsp_pkg::TUNE_OFF, ~{26'h0, v}, OK_W);
        wstrb_i <= 4'hf;
        bus(1'b0, scsp_pkg::TUNE_OFF, 32'h0, {scsp_pkg::AXI_OKAY, 26'h0, v});
        check("tune", 32'(fast_osc_tune_o), 32'(v));
        bus(1'b1, 8'h10, $random(seed), ERR_W);
        bus(1'b0, 8'h10, 32'h0, ERR_W);
        for (int k = 0; k < 8; k++) begin
            w = {16'h0, 5'($random(seed)), 3'(k), 8'h20};
            bus(1'b1, scsp_pkg::CLOCK_DIVISOR_REGISTER_OFF, w, OK_W);
            bus(1'b0, scsp_pkg::CLOCK_DIVISOR_REGISTER_OFF, 32'h0, {scsp_pkg::AXI_OKAY, w & {16'h0, scsp_pkg::CLOCK_DIVISOR_REGISTER_MASK}});
            measure(4 * (k == 7 ? 256 : 1 << k));
        end
        foreach (src_tab[i]) begin
            restart(src_tab[i], 2'h3);
            measure(per_tab[i]);
        end
        for (int m = 0; m < 3; m++) begin
            restart(3'h2, 2'(m));
            measure(6);
            check("drive_mode", 32'(primary_drive_mode_o), 32'(m));
            restart(3'h3, 2'(m));
            pll(5'h00, 9'h000, 2'h0, 12);
            check("drive_mode", 32'(primary_drive_mode_o), 32'(m));
            bus(1'b0, scsp_pkg::STATUS_OFF, 32'h0, {scsp_pkg::AXI_OKAY, 22'h0, 2'h3, 2'h0, 2'(m), 4'h3});
        end
        restart(3'h1, 2'h0);
        pll(5'h00, 9'h000, 2'h3, 32);
        pll(5'h02, 9'h002, 2'h1, 16);
        pll(5'h01, 9'h004, 2'h0, 4);
        report_and_stop();
    end
endmodule
